// ---- shared/vrsel_pkg.sv ----
package vrsel_pkg;

    // ==========================================================
    // Register map: indices, byte address is four times index
    localparam int VRSEL_ADDR_W = 8;
    localparam int VRSEL_REG_W = 8;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_ADC_IDX = 8'h00;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_DAC_IDX = 8'h02;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_CMP_IDX = 8'h04;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_STAT_IDX = 8'h06;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_ADC_ADDR = VRSEL_ADC_IDX << 2;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_DAC_ADDR = VRSEL_DAC_IDX << 2;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_CMP_ADDR = VRSEL_CMP_IDX << 2;
    localparam logic [VRSEL_ADDR_W-1:0] VRSEL_STAT_ADDR =
        VRSEL_STAT_IDX << 2;

    // ==========================================================
    // Field layout and reset values
    localparam int VRSEL_FORCE_BIT = 7;
    localparam int VRSEL_LVL_HI = 2;
    localparam int VRSEL_LVL_LO = 0;
    localparam int VRSEL_RSVD_HI = 6;
    localparam int VRSEL_RSVD_LO = 3;
    localparam logic [VRSEL_REG_W-1:0] VRSEL_CTRL_RESET = 8'h00;
    localparam logic [VRSEL_REG_W-1:0] VRSEL_CTRL_WMASK = 8'h87;
    localparam int VRSEL_STAT_EN_LO = 0;
    localparam int VRSEL_STAT_RSVD_LO = 8;

    // ==========================================================
    // Level-select codes
    typedef enum logic [2:0] {
        VRSEL_INTERNAL_LEVEL_LOWEST = 3'b000,
        VRSEL_INTERNAL_LEVEL_SECOND = 3'b001,
        VRSEL_INTERNAL_LEVEL_HIGHEST = 3'b010,
        VRSEL_INTERNAL_LEVEL_MID = 3'b011,
        VRSEL_LEVEL_RSVD_A = 3'b100,
        VRSEL_LEVEL_SUPPLY = 3'b101,
        VRSEL_LEVEL_EXT_PIN = 3'b110,
        VRSEL_LEVEL_RSVD_B = 3'b111
    } vrsel_level_t;

    // ==========================================================
    // Reference source control toward the analog side
    typedef struct packed {
        logic enable;
        logic [2:0] level_select;
        logic internal;
        logic supply;
        logic external_reference_pin;
        logic reserved_code;
    } vrsel_ref_t;

endpackage

// ---- rtl/vrsel_chan.sv ----
`timescale 1ns/1ns
`default_nettype none

module vrsel_chan
    import vrsel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wr_i,
    input wire logic [VRSEL_REG_W-1:0] wdata_i,
    input wire logic req_i,
    output logic [VRSEL_REG_W-1:0] ctrl_o,
    output vrsel_ref_t ref_o
);

    // ==========================================================
    // Control register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_o <= VRSEL_CTRL_RESET;
        end else if (wr_i) begin
            ctrl_o <= wdata_i & VRSEL_CTRL_WMASK;
        end
    end

    // ==========================================================
    // Enable and source routing
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_o <= '0;
        end else begin
            ref_o.enable <= req_i | ctrl_o[VRSEL_FORCE_BIT];
            ref_o.level_select <= ctrl_o[VRSEL_LVL_HI:VRSEL_LVL_LO];
            ref_o.internal <= 1'b0;
            ref_o.supply <= 1'b0;
            ref_o.external_reference_pin <= 1'b0;
            ref_o.reserved_code <= 1'b0;
            // Reserved codes route nothing rather than a guess
            case (vrsel_level_t'(ctrl_o[VRSEL_LVL_HI:VRSEL_LVL_LO]))
                VRSEL_INTERNAL_LEVEL_LOWEST,
                VRSEL_INTERNAL_LEVEL_SECOND,
                VRSEL_INTERNAL_LEVEL_HIGHEST,
                VRSEL_INTERNAL_LEVEL_MID: begin
                    ref_o.internal <= 1'b1;
                end
                VRSEL_LEVEL_SUPPLY: begin
                    ref_o.supply <= 1'b1;
                end
                VRSEL_LEVEL_EXT_PIN: begin
                    ref_o.external_reference_pin <= 1'b1;
                end
                default: begin
                    ref_o.reserved_code <= 1'b1;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- rtl/vrsel_regs.sv ----
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none

module vrsel_regs
    import vrsel_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [VRSEL_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic adc_req_i,
    input wire logic dac_req_i,
    input wire logic cmp_req_i,
    output vrsel_ref_t adc_ref_o,
    output vrsel_ref_t dac_ref_o,
    output vrsel_ref_t cmp_ref_o
);

    // ==========================================================
    // Bus phases
    logic setup;
    logic wr_acc;
    logic wr_adc;
    logic wr_dac;
    logic wr_cmp;
    logic [VRSEL_REG_W-1:0] adc_ctrl;
    logic [VRSEL_REG_W-1:0] dac_ctrl;
    logic [VRSEL_REG_W-1:0] cmp_ctrl;
    logic [31:0] status;
    logic [31:0] next_rdata;
    logic next_err;

    assign setup = psel_i && !penable_i;
    // A write lands only on the completing edge of its access phase
    assign wr_acc = psel_i && penable_i && pready_o && pwrite_i &&
        !pslverr_o;
    // Only byte lane 0 carries writable register bits
    assign wr_adc = wr_acc && pstrb_i[0] && (paddr_i == VRSEL_ADC_ADDR);
    assign wr_dac = wr_acc && pstrb_i[0] && (paddr_i == VRSEL_DAC_ADDR);
    assign wr_cmp = wr_acc && pstrb_i[0] && (paddr_i == VRSEL_CMP_ADDR);

    // ==========================================================
    // Reference channels
    vrsel_chan u_adc (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_adc),
        .wdata_i(pwdata_i[VRSEL_REG_W-1:0]),
        .req_i(adc_req_i),
        .ctrl_o(adc_ctrl),
        .ref_o(adc_ref_o)
    );

    vrsel_chan u_dac (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_dac),
        .wdata_i(pwdata_i[VRSEL_REG_W-1:0]),
        .req_i(dac_req_i),
        .ctrl_o(dac_ctrl),
        .ref_o(dac_ref_o)
    );

    vrsel_chan u_cmp (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(wr_cmp),
        .wdata_i(pwdata_i[VRSEL_REG_W-1:0]),
        .req_i(cmp_req_i),
        .ctrl_o(cmp_ctrl),
        .ref_o(cmp_ref_o)
    );

    // ==========================================================
    // Status view of the live sources
    always_comb begin
        status = '0;
        status[VRSEL_STAT_EN_LO] = adc_ref_o.enable;
        status[VRSEL_STAT_EN_LO + 1] = dac_ref_o.enable;
        status[VRSEL_STAT_EN_LO + 2] = cmp_ref_o.enable;
        status[VRSEL_STAT_RSVD_LO] = adc_ref_o.reserved_code;
        status[VRSEL_STAT_RSVD_LO + 1] = dac_ref_o.reserved_code;
        status[VRSEL_STAT_RSVD_LO + 2] = cmp_ref_o.reserved_code;
    end

    // ==========================================================
    // Read decode
    always_comb begin
        next_rdata = '0;
        next_err = 1'b0;
        if (paddr_i == VRSEL_ADC_ADDR) begin
            next_rdata = 32'(adc_ctrl);
        end else if (paddr_i == VRSEL_DAC_ADDR) begin
            next_rdata = 32'(dac_ctrl);
        end else if (paddr_i == VRSEL_CMP_ADDR) begin
            next_rdata = 32'(cmp_ctrl);
        end else if (paddr_i == VRSEL_STAT_ADDR) begin
            next_rdata = status;
        end else begin
            next_err = 1'b1;
        end
    end

    // ==========================================================
    // Answer: one access cycle, no wait states
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup && next_err;
        end
    end

    // Data captured at setup so it holds through the access phase
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o <= '0;
        end else if (setup) begin
            prdata_o <= pwrite_i ? '0 : next_rdata;
        end else if (pready_o) begin
            prdata_o <= '0;
        end
    end

    // ==========================================================
    // Checks
    logic wr_seen;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_seen <= 1'b0;
        end else if (wr_adc || wr_dac || wr_cmp) begin
            wr_seen <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_adc_force;
        wr_adc && pwdata_i[VRSEL_FORCE_BIT]
            |=> ##1 adc_ref_o.enable;
    endproperty
    a_adc_force: assert property (p_adc_force)
        else $error("converter force-on did not enable source");

    property p_dac_force;
        wr_dac && pwdata_i[VRSEL_FORCE_BIT] && !adc_ctrl[VRSEL_FORCE_BIT]
            |=> dac_ctrl[VRSEL_FORCE_BIT] && !adc_ctrl[VRSEL_FORCE_BIT]
            ##1 dac_ref_o.enable;
    endproperty
    a_dac_force: assert property (p_dac_force)
        else $error("output force-on wrong or leaked");

    property p_cmp_force;
        wr_cmp && pwdata_i[VRSEL_FORCE_BIT] && !cmp_req_i
            |=> ##1 cmp_ref_o.enable;
    endproperty
    a_cmp_force: assert property (p_cmp_force)
        else $error("comparator force-on did not enable source");

    property p_auto_off;
        (!cmp_ctrl[VRSEL_FORCE_BIT] && !cmp_req_i) [*3]
            |-> !cmp_ref_o.enable;
    endproperty
    a_auto_off: assert property (p_auto_off)
        else $error("unrequested source left on");

    property p_force_hold;
        adc_ctrl[VRSEL_FORCE_BIT] && !adc_req_i |=> adc_ref_o.enable;
    endproperty
    a_force_hold: assert property (p_force_hold)
        else $error("forced source dropped");

    property p_req_on;
        dac_req_i |=> dac_ref_o.enable;
    endproperty
    a_req_on: assert property (p_req_on)
        else $error("request did not enable source");

    property p_adc_level;
        wr_adc |=> ##1
            adc_ref_o.level_select == $past(pwdata_i[2:0], 2);
    endproperty
    a_adc_level: assert property (p_adc_level)
        else $error("converter level not delivered");

    property p_dac_level;
        wr_dac |=> ##1
            dac_ref_o.level_select == $past(pwdata_i[2:0], 2) &&
            $stable(adc_ref_o.level_select);
    endproperty
    a_dac_level: assert property (p_dac_level)
        else $error("output level wrong or disturbed others");

    property p_cmp_level;
        wr_cmp |=> ##1
            cmp_ref_o.level_select == $past(pwdata_i[2:0], 2) &&
            $stable(dac_ref_o.level_select);
    endproperty
    a_cmp_level: assert property (p_cmp_level)
        else $error("comparator level wrong or disturbed others");

    property p_internal;
        cmp_ctrl[VRSEL_LVL_HI:VRSEL_LVL_LO] == VRSEL_INTERNAL_LEVEL_HIGHEST
            |=> cmp_ref_o.internal && !cmp_ref_o.supply &&
            !cmp_ref_o.external_reference_pin;
    endproperty
    a_internal: assert property (p_internal)
        else $error("internal level not routed");

    property p_supply;
        adc_ctrl[VRSEL_LVL_HI:VRSEL_LVL_LO] == VRSEL_LEVEL_SUPPLY
            |=> adc_ref_o.supply && !adc_ref_o.internal &&
            !adc_ref_o.external_reference_pin;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply code not routed");

    property p_ext_pin;
        dac_ctrl[VRSEL_LVL_HI:VRSEL_LVL_LO] == VRSEL_LEVEL_EXT_PIN
            |=> dac_ref_o.external_reference_pin && !dac_ref_o.supply;
    endproperty
    a_ext_pin: assert property (p_ext_pin)
        else $error("external pin code not routed");

    property p_reset_val;
        !wr_seen |-> adc_ctrl == VRSEL_CTRL_RESET &&
            dac_ctrl == VRSEL_CTRL_RESET && cmp_ctrl == VRSEL_CTRL_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("register left reset value without a write");

    property p_rsvd_zero;
        pready_o && !pwrite_i
            |-> prdata_o[VRSEL_RSVD_HI:VRSEL_RSVD_LO] == '0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bits read nonzero");

    property p_rsvd_store;
        ((adc_ctrl | dac_ctrl | cmp_ctrl) & ~VRSEL_CTRL_WMASK) == '0;
    endproperty
    a_rsvd_store: assert property (p_rsvd_store)
        else $error("unimplemented control bits stored");

    property p_adc_auto;
        !adc_ctrl[VRSEL_FORCE_BIT] && !adc_req_i
            |=> !adc_ref_o.enable;
    endproperty
    a_adc_auto: assert property (p_adc_auto)
        else $error("converter source on without request");

    property p_dac_auto;
        !dac_ctrl[VRSEL_FORCE_BIT] && !dac_req_i
            |=> !dac_ref_o.enable;
    endproperty
    a_dac_auto: assert property (p_dac_auto)
        else $error("output source on without request");

    property p_adc_req_on;
        adc_req_i |=> adc_ref_o.enable;
    endproperty
    a_adc_req_on: assert property (p_adc_req_on)
        else $error("converter request did not enable source");

    property p_cmp_req_on;
        cmp_req_i |=> cmp_ref_o.enable;
    endproperty
    a_cmp_req_on: assert property (p_cmp_req_on)
        else $error("comparator request did not enable source");

    property p_dac_hold;
        dac_ctrl[VRSEL_FORCE_BIT] |=> dac_ref_o.enable;
    endproperty
    a_dac_hold: assert property (p_dac_hold)
        else $error("forced output source dropped");

    property p_cmp_hold;
        cmp_ctrl[VRSEL_FORCE_BIT] |=> cmp_ref_o.enable;
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("forced comparator source dropped");

    property p_adc_rsvd_code;
        (adc_ctrl[VRSEL_LVL_HI:VRSEL_LVL_LO] == VRSEL_LEVEL_RSVD_A ||
            adc_ctrl[VRSEL_LVL_HI:VRSEL_LVL_LO] == VRSEL_LEVEL_RSVD_B)
            |=> adc_ref_o.reserved_code && !adc_ref_o.internal &&
            !adc_ref_o.supply && !adc_ref_o.external_reference_pin;
    endproperty
    a_adc_rsvd_code: assert property (p_adc_rsvd_code)
        else $error("reserved code routed a source");

    property p_adc_lowest;
        adc_ctrl[VRSEL_LVL_HI:VRSEL_LVL_LO] == VRSEL_INTERNAL_LEVEL_LOWEST
            |=> adc_ref_o.internal && !adc_ref_o.reserved_code;
    endproperty
    a_adc_lowest: assert property (p_adc_lowest)
        else $error("lowest internal level not routed");

    property p_adc_isolate;
        wr_adc |=> $stable(dac_ctrl) && $stable(cmp_ctrl);
    endproperty
    a_adc_isolate: assert property (p_adc_isolate)
        else $error("converter write disturbed other registers");

    property p_cmp_isolate;
        wr_cmp |=> $stable(adc_ctrl) && $stable(dac_ctrl);
    endproperty
    a_cmp_isolate: assert property (p_cmp_isolate)
        else $error("comparator write disturbed other registers");

endmodule

`default_nettype wire

// ---- tb/vrsel_consumer_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Consumers asking for their reference; slow mode lags a cycle
module vrsel_consumer_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] want_i,
    input wire logic slow_i,
    output logic adc_req_o,
    output logic dac_req_o,
    output logic cmp_req_o
);
    logic [2:0] lag;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            lag <= 3'h0;
        else
            lag <= want_i;
    end

    assign {cmp_req_o, dac_req_o, adc_req_o} = slow_i ? lag : want_i;
endmodule

`default_nettype wire

// ---- tb/vrsel_regs_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module vrsel_regs_bench;
    import vrsel_pkg::*;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic psel_i = 1'h0;
    logic penable_i = 1'h0;
    logic pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'hF;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic adc_req_i;
    logic dac_req_i;
    logic cmp_req_i;
    logic [2:0] want = 3'h0;
    logic slow = 1'h0;
    vrsel_ref_t adc_ref_o;
    vrsel_ref_t dac_ref_o;
    vrsel_ref_t cmp_ref_o;
    vrsel_ref_t refs [3];
    logic [7:0] addrs [3];
    int err_total = 0;
    int comparisons = 0;

    always #50 clk_i = ~clk_i;
    assign refs[0] = adc_ref_o;
    assign refs[1] = dac_ref_o;
    assign refs[2] = cmp_ref_o;
    assign addrs[0] = VRSEL_ADC_ADDR;
    assign addrs[1] = VRSEL_DAC_ADDR;
    assign addrs[2] = VRSEL_CMP_ADDR;

    vrsel_regs vrsel_regs_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .adc_req_i(adc_req_i), .dac_req_i(dac_req_i),
        .cmp_req_i(cmp_req_i), .adc_ref_o(adc_ref_o),
        .dac_ref_o(dac_ref_o), .cmp_ref_o(cmp_ref_o));

    vrsel_consumer_model vrsel_consumer_model_i (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .want_i(want), .slow_i(slow),
        .adc_req_o(adc_req_i), .dac_req_o(dac_req_i),
        .cmp_req_o(cmp_req_i));

    // ==========================================================
    // Reporting and comparison
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic fail(input string msg);
        err_total++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
            fail($sformatf("word %h expected %h", got, exp));
    endtask

    task automatic chk_ref(input vrsel_ref_t got, input vrsel_ref_t exp);
        comparisons++;
        if (got !== exp)
            fail($sformatf("ref %h expected %h", got, exp));
    endtask

    function automatic vrsel_ref_t exp_ref(input logic en,
                                           input logic [2:0] c);
        exp_ref = '{en, c, c < 3'h4, c == 3'h5, c == 3'h6,
                    c == 3'h4 || c == 3'h7};
    endfunction

    // ==========================================================
    // Bus master
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_i);
        psel_i <= 1'h1;
        penable_i <= 1'h0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'h1;
        // Ready, data and error all taken at the edge that ends the access
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (pready_o === 1'h1)
                break;
        end
        if (n == 16) begin
            fail("no ready");
            end_sim();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hF);
        logic [31:0] rd;
        logic err;
        apb(1'h1, a, {24'h0, d}, s, rd, err);
        chk_word({31'h0, err}, 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'h0, a, 32'h0, 4'h0, rd, err);
        chk_word(rd, exp);
        chk_word({31'h0, err}, 32'h0);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset(input logic pulse);
        if (pulse) begin
            @(posedge clk_i);
            rst_b_i <= 1'h0;
            repeat (2) @(posedge clk_i);
            rst_b_i <= 1'h1;
        end
        settle();
        for (int i = 0; i < 3; i++) begin
            rd_chk(addrs[i], 32'h0);
            chk_ref(refs[i], exp_ref(1'h0, 3'h0));
        end
        $display("test reset done");
    endtask

    task automatic test_codes();
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 8; c++) begin
                wr(addrs[i], 8'(c));
                settle();
                rd_chk(addrs[i], 32'(c));
                chk_ref(refs[i], exp_ref(1'h0, 3'(c)));
            end
        end
        // Distinct codes side by side show the selects stay apart
        wr(addrs[0], 8'h03);
        wr(addrs[1], 8'h05);
        wr(addrs[2], 8'h06);
        settle();
        chk_ref(adc_ref_o, exp_ref(1'h0, 3'h3));
        chk_ref(dac_ref_o, exp_ref(1'h0, 3'h5));
        chk_ref(cmp_ref_o, exp_ref(1'h0, 3'h6));
        $display("test codes done");
    endtask

    task automatic test_force();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            slow <= 1'(i);
            wr(addrs[i], 8'h81);
            settle();
            chk_ref(refs[i], exp_ref(1'h1, 3'h1));
            chk_word({31'h0, refs[(i + 1) % 3].enable}, 32'h0);
            wr(addrs[i], 8'h01);
            settle();
            chk_ref(refs[i], exp_ref(1'h0, 3'h1));
            @(posedge clk_i);
            want <= 3'h1 << i;
            settle();
            chk_ref(refs[i], exp_ref(1'h1, 3'h1));
            wr(addrs[i], 8'h81);
            want <= 3'h0;
            settle();
            chk_ref(refs[i], exp_ref(1'h1, 3'h1));
            // Force left set on channel 0 would trip the last pass's neighbour check
            wr(addrs[i], 8'h01);
        end
        $display("test force done");
    endtask

    task automatic test_reserved();
        logic [31:0] rd;
        logic err;
        wr(addrs[0], 8'hFF);
        rd_chk(addrs[0], 32'h87);
        wr(addrs[0], 8'h00, 4'h0);
        settle();
        rd_chk(addrs[0], 32'h87);
        chk_ref(adc_ref_o, exp_ref(1'h1, 3'h7));
        rd_chk(VRSEL_STAT_ADDR, 32'h101);
        apb(1'h1, 8'h04, 32'h0, 4'hF, rd, err);
        chk_word({31'h0, err}, 32'h1);
        rd_chk(addrs[0], 32'h87);
        $display("test reserved done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'h1;
        test_reset(1'h0);
        test_codes();
        test_force();
        test_reserved();
        test_reset(1'h1);
        end_sim();
    end
endmodule

`default_nettype wire
